// >>> verification/pcb_core_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// core event sources and time base
// ----------------------------------------
module pcb_core_model
    import pcb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire pcb_evt_t evt_cmd_in,
    input wire logic [31:0] toggle_mask_in,
    output pcb_evt_t events_out,
    output logic [31:0] tb_lower_out,
    output pcb_sample_src_t sample_src_out
);
    // fixed addresses offered for capture
    assign sample_src_out = {32'h0000_1A10, 32'h0000_2B20,
        32'h0000_3C30, 32'h0000_4D40};

    initial begin
        events_out = '0;
        tb_lower_out = 32'h0000_0000;
    end

    // events and time base move just after the falling edge
    always @(negedge clk_sys_in) begin
        events_out <= evt_cmd_in;
        tb_lower_out <= tb_lower_out ^ toggle_mask_in;
    end
endmodule

// >>> verification/pcb_event_sampler_props.sv
`timescale 1ns/1ps
`include "pcb_defines.svh"

module pcb_event_sampler_props
    import pcb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire pcb_spr_req_t spr_req_in,
    input wire logic mon_int_req_in,
    input wire logic external_interrupt_enable_in,
    input wire logic spr_rd_valid_out,
    input wire logic spr_priv_fault_out,
    input wire logic monitor_interrupt_pending_out,
    input wire logic monitor_interrupt_take_out,
    input wire logic [31:0] event_counter_b_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    logic acc;
    assign acc = spr_req_in.rd | spr_req_in.wr;

    chk_instr_read: assert property (
        spr_req_in.rd && spr_req_in.supervisor &&
        spr_req_in.num == `PCB_SPR_INSTR_SMP |-> ##2 spr_rd_valid_out)
        else $error("sample instruction read not answered");
    chk_opnd_read: assert property (
        spr_req_in.rd && spr_req_in.supervisor &&
        spr_req_in.num == `PCB_SPR_OPND_SMP |-> ##2 spr_rd_valid_out)
        else $error("sample operand read not answered");
    chk_user_fault: assert property (
        acc && !spr_req_in.supervisor && (spr_req_in.num ==
        `PCB_SPR_INSTR_SMP || spr_req_in.num == `PCB_SPR_OPND_SMP)
        |=> spr_priv_fault_out)
        else $error("user access without fault");
    chk_sup_no_fault: assert property (
        acc && spr_req_in.supervisor |=> !spr_priv_fault_out)
        else $error("fault on supervisor access");
    chk_pend_hold: assert property (
        monitor_interrupt_pending_out && !external_interrupt_enable_in
        |=> monitor_interrupt_pending_out)
        else $error("pending dropped while masked");
    chk_take_after: assert property (
        monitor_interrupt_pending_out && external_interrupt_enable_in
        |=> monitor_interrupt_take_out)
        else $error("unmasked interrupt not taken");
    chk_take_cause: assert property (
        monitor_interrupt_take_out |-> $past(monitor_interrupt_pending_out)
        && $past(external_interrupt_enable_in))
        else $error("take without pending and enable");
    chk_pend_rise: assert property (
        $rose(monitor_interrupt_pending_out) |-> $past(mon_int_req_in))
        else $error("pending without request");
    chk_count_step: assert property (
        !$past(spr_req_in.wr) |->
        event_counter_b_out - $past(event_counter_b_out) <= 32'h4)
        else $error("counter step above four");

    cov_take: cover property (monitor_interrupt_take_out);
    cov_fault: cover property (spr_priv_fault_out);
    cov_pend: cover property ($rose(monitor_interrupt_pending_out));
endmodule

bind pcb_event_sampler pcb_event_sampler_props u_props (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .spr_req_in(spr_req_in),
    .mon_int_req_in(mon_int_req_in),
    .external_interrupt_enable_in(external_interrupt_enable_in),
    .spr_rd_valid_out(spr_rd_valid_out),
    .spr_priv_fault_out(spr_priv_fault_out),
    .monitor_interrupt_pending_out(monitor_interrupt_pending_out),
    .monitor_interrupt_take_out(monitor_interrupt_take_out),
    .event_counter_b_out(event_counter_b_out)
);

// >>> verification/pcb_event_sampler_tb.sv
`timescale 1ns/1ps
`include "pcb_defines.svh"

module pcb_event_sampler_tb
    import pcb_pkg::*;
;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    pcb_spr_req_t spr_req = '0;
    pcb_evt_t evt_cmd = {3'h3, 3'h2, 3'h7, 2'h3, 10'h3FF, 3'h4, 1'h1};
    pcb_evt_t events;
    pcb_sample_src_t sample_src;
    logic [31:0] toggle_mask = 32'h0000_0001;
    logic [31:0] tb_lower, rdata, cnt_b;
    logic [1:0] selector = 2'h3;
    logic int_req = 1'b0;
    logic int_thr = 1'b0;
    logic ext_en = 1'b0;
    logic rvalid, fault, pend, take, got_ans;
    int error_cnt = 0;
    int total_checks = 0;

    always #10 clk_sys_in = ~clk_sys_in;

    pcb_core_model u_core (.clk_sys_in(clk_sys_in), .evt_cmd_in(evt_cmd),
        .toggle_mask_in(toggle_mask), .events_out(events),
        .tb_lower_out(tb_lower), .sample_src_out(sample_src));

    pcb_event_sampler uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .spr_req_in(spr_req), .events_in(events), .tb_lower_in(tb_lower),
        .timebase_bit_selector_in(selector), .sample_src_in(sample_src),
        .mon_int_req_in(int_req), .mon_int_threshold_in(int_thr),
        .external_interrupt_enable_in(ext_en), .spr_rdata_out(rdata),
        .spr_rd_valid_out(rvalid), .spr_priv_fault_out(fault),
        .monitor_interrupt_pending_out(pend),
        .monitor_interrupt_take_out(take), .event_counter_b_out(cnt_b));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task check_word(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task complete_run;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task spr_acc(input logic rd, input logic wr, input logic [9:0] num,
        input logic [31:0] data, input logic sup);
        // idle edge keeps back-to-back transfers apart
        @(negedge clk_sys_in);
        spr_req = {rd, wr, num, data, sup};
        @(negedge clk_sys_in);
        spr_req = '0;
    endtask

    task spr_write(input logic [9:0] num, input logic [31:0] data);
        spr_acc(1'b1 ^ 1'b1, 1'b1, num, data, 1'b1);
    endtask

    task spr_read(input logic [9:0] num, output logic [31:0] data);
        data = 'x;
        got_ans = 1'b0;
        spr_acc(1'b1, 1'b0, num, 32'h0, 1'b1);
        repeat (4) begin
            if (!got_ans && rvalid === 1'b1) begin
                data = rdata;
                got_ans = 1'b1;
            end
            @(negedge clk_sys_in);
        end
    endtask

    function automatic logic [31:0] exp_rate(input logic [5:0] c);
        if (c == 6'h02) return 32'h3;
        if (c == 6'h04 || c == 6'h08) return 32'h2;
        if (c == 6'h12) return 32'h4;
        if (c == 6'h00 || c > 6'h14) return 32'h0;
        return 32'h1;
    endfunction

    // four counting edges between counter clear and select hold
    task measure(input logic [5:0] code, input logic [31:0] exp);
        logic [31:0] v;
        spr_write(`PCB_SPR_CTRL0, {26'h0, code});
        spr_write(`PCB_SPR_CNT_B, 32'h0);
        repeat (2) @(negedge clk_sys_in);
        spr_write(`PCB_SPR_CTRL0, 32'h0);
        spr_read(`PCB_SPR_CNT_B, v);
        check_word($sformatf("count code %h", code), exp, v);
        check_word("counter output", exp, cnt_b);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task test_reset;
        logic [31:0] v;
        spr_read(`PCB_SPR_INSTR_SMP, v);
        check_word("instr sample reset", 32'h0, v);
        spr_read(`PCB_SPR_OPND_SMP, v);
        check_word("operand sample reset", 32'h0, v);
        check_word("pending reset", 32'h0, {31'h0, pend});
    endtask

    task test_codes;
        for (int c = 0; c < 8; c++)
            measure(c[5:0], 4 * exp_rate(c[5:0]));
        for (int c = 8; c < 16; c++)
            measure(c[5:0], 4 * exp_rate(c[5:0]));
        for (int c = 16; c < 23; c++)
            measure(c[5:0], 4 * exp_rate(c[5:0]));
    endtask

    task test_timebase;
        for (int s = 0; s < 4; s++) begin
            selector = s[1:0];
            toggle_mask = 32'h1 << ((s == 3) ? 0 : 16 - 4 * s);
            repeat (2) @(negedge clk_sys_in);
            measure(`PCB_SEL_TBTRANS, 32'h4);
        end
        selector = 2'h0;
        toggle_mask = 32'h0000_1000;
        repeat (2) @(negedge clk_sys_in);
        measure(`PCB_SEL_TBTRANS, 32'h0);
    endtask

    task test_illegal;
        evt_cmd.branches_completed = 2'h1;
        evt_cmd.instr_completed = 3'h5;
        measure(`PCB_SEL_BRANCH, 32'h0);
        measure(`PCB_SEL_COMPL, 32'h0);
    endtask

    task test_disable;
        logic [31:0] v;
        spr_write(`PCB_SPR_CTRL0, 32'h8000_0001);
        spr_write(`PCB_SPR_CNT_B, 32'h0000_0007);
        repeat (3) @(negedge clk_sys_in);
        spr_read(`PCB_SPR_CNT_B, v);
        check_word("disabled count", 32'h7, v);
        check_word("disabled output", 32'h7, cnt_b);
    endtask

    task test_access;
        logic [31:0] v;
        spr_write(`PCB_SPR_INSTR_SMP, 32'hCAFE_0001);
        spr_read(`PCB_SPR_INSTR_SMP, v);
        check_word("instr sample", 32'hCAFE_0001, v);
        spr_write(`PCB_SPR_OPND_SMP, 32'h5A5A_0F0F);
        spr_read(`PCB_SPR_OPND_SMP, v);
        check_word("operand sample", 32'h5A5A_0F0F, v);
        spr_acc(1'b0, 1'b1, `PCB_SPR_INSTR_SMP, 32'h1111_1111, 1'b0);
        check_word("user write fault", 32'h1, {31'h0, fault});
        spr_acc(1'b1, 1'b0, `PCB_SPR_OPND_SMP, 32'h0, 1'b0);
        check_word("user read fault", 32'h1, {31'h0, fault});
        spr_read(`PCB_SPR_INSTR_SMP, v);
        check_word("instr after user", 32'hCAFE_0001, v);
        spr_read(10'h3BC, v);
        check_word("unmapped answer", 32'h0, {31'h0, got_ans});
    endtask

    task fire_irq(input logic thr, input logic [31:0] ea_i, ea_d);
        logic [31:0] v;
        ext_en = 1'b0;
        spr_write(`PCB_SPR_CTRL0, 32'h0400_0000);
        int_thr = thr;
        int_req = 1'b1;
        @(negedge clk_sys_in);
        int_req = 1'b0;
        int_thr = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check_word("pending masked", 32'h1, {31'h0, pend});
        spr_read(`PCB_SPR_INSTR_SMP, v);
        check_word("captured instr", ea_i, v);
        spr_read(`PCB_SPR_OPND_SMP, v);
        check_word("captured operand", ea_d, v);
        spr_read(`PCB_SPR_CTRL0, v);
        check_word("enable cleared", 32'h0, v);
        ext_en = 1'b1;
        v = 32'h0;
        repeat (4) begin
            @(negedge clk_sys_in);
            if (take === 1'b1) v = 32'h1;
        end
        check_word("interrupt taken", 32'h1, v);
        check_word("pending after take", 32'h0, {31'h0, pend});
    endtask

    task test_irq;
        ext_en = 1'b0;
        spr_write(`PCB_SPR_CTRL0, 32'h0);
        int_req = 1'b1;
        @(negedge clk_sys_in);
        int_req = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check_word("disabled request", 32'h0, {31'h0, pend});
        fire_irq(1'b1, 32'h0000_1A10, 32'h0000_2B20);
        fire_irq(1'b0, 32'h0000_3C30, 32'h0000_4D40);
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        @(negedge clk_sys_in);
        test_reset;
        test_codes;
        test_timebase;
        test_illegal;
        test_disable;
        test_access;
        test_irq;
        complete_run;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_in);
        error_cnt++;
        complete_run;
    end
endmodule

// >>> verilog/pcb_defines.svh
// Overview of operation
// - counter b event select is the six-bit field, control bits 0 to 5
// - select zero holds counter b; select one counts processor cycles
// - select 2 adds instructions completed per cycle, legal 0 to 4
// - select 3 counts time-base bit transitions, bit chosen by selector
// - select 4 counts dispatches; select 5 adds cycles of load misses
// - select 6 counts data cache fills; select 7 itlb misses
// - select 8 adds branches completed: 00 none, 10 one, 11 two, 01 bad
// - selects 9, 10, 11: reservations, speculative mfspr, cache invalidates
// - selects 13 to 15: branch, simple, complex unit results
// - selects 16, 17, 19: dispatches to branch, simple, complex units
// - select 18 adds loads completed per cycle, 0 to 4
// - select 20 counts snoop hits
// - threshold interrupt loads instruction sample with causing address
// - other interrupt loads instruction sample with last completed address
// - threshold interrupt loads operand sample with its operand address
// - other interrupt loads operand sample with a nearby operand address
// - instruction sample is register 955, read and write
// - operand sample is register 959, read and write
// - sample registers reachable only at supervisor level
// - signalled interrupt stays pending until external enable is set
// - hardware clears the interrupt enable bit when it signals
`ifndef PCB_DEFINES_SVH
`define PCB_DEFINES_SVH

`define PCB_SPR_W 10
`define PCB_SPR_CTRL0 10'h3B8
`define PCB_SPR_CNT_B 10'h3BA
`define PCB_SPR_INSTR_SMP 10'h3BB
`define PCB_SPR_OPND_SMP 10'h3BF

`define PCB_SEL_LSB 0
`define PCB_SEL_MSB 5
`define PCB_INT_EN_BIT 26
`define PCB_DIS_BIT 31
`define PCB_CTRL_RESET 32'h0000_0000
`define PCB_CNT_RESET 32'h0000_0000
`define PCB_SAMPLE_RESET 32'h0000_0000

`define PCB_TB_BIT_47 5'h10
`define PCB_TB_BIT_51 5'h0C
`define PCB_TB_BIT_55 5'h08
`define PCB_TB_BIT_63 5'h00

`define PCB_QUAD_MAX 3'h4
`define PCB_IDX_INSTR 1'h0
`define PCB_IDX_OPND 1'h1

`define PCB_SEL_HOLD 6'h00
`define PCB_SEL_CYCLES 6'h01
`define PCB_SEL_COMPL 6'h02
`define PCB_SEL_TBTRANS 6'h03
`define PCB_SEL_DISP 6'h04
`define PCB_SEL_LDMISS 6'h05
`define PCB_SEL_DCFILL 6'h06
`define PCB_SEL_ITLB 6'h07
`define PCB_SEL_BRANCH 6'h08
`define PCB_SEL_RESV 6'h09
`define PCB_SEL_MFSPR 6'h0A
`define PCB_SEL_ICBI 6'h0B
`define PCB_SEL_FLUSH 6'h0C
`define PCB_SEL_BRU_RES 6'h0D
`define PCB_SEL_SIU_RES 6'h0E
`define PCB_SEL_CIU_RES 6'h0F
`define PCB_SEL_BRU_DSP 6'h10
`define PCB_SEL_SIU_DSP 6'h11
`define PCB_SEL_LOADS 6'h12
`define PCB_SEL_CIU_DSP 6'h13
`define PCB_SEL_SNOOP 6'h14

`endif

// >>> verilog/pcb_event_sampler.sv
`timescale 1ns/1ps

module pcb_event_sampler
    import pcb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire pcb_spr_req_t spr_req_in,
    input wire pcb_evt_t events_in,
    input wire logic [31:0] tb_lower_in,
    input wire logic [1:0] timebase_bit_selector_in,
    input wire pcb_sample_src_t sample_src_in,
    input wire logic mon_int_req_in,
    input wire logic mon_int_threshold_in,
    input wire logic external_interrupt_enable_in,
    output logic [31:0] spr_rdata_out,
    output logic spr_rd_valid_out,
    output logic spr_priv_fault_out,
    output logic monitor_interrupt_pending_out,
    output logic monitor_interrupt_take_out,
    output logic [31:0] event_counter_b_out
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    function automatic logic [2:0] quad_count(input logic [2:0] v);
        quad_count = (v > `PCB_QUAD_MAX) ? 3'h0 : v;
    endfunction

    function automatic logic [2:0] branch_count(input logic [1:0] b);
        case (b)
            2'h2: branch_count = 3'h1;
            2'h3: branch_count = 3'h2;
            default: branch_count = 3'h0;
        endcase
    endfunction

    function automatic logic [2:0] one(input logic b);
        one = {2'h0, b};
    endfunction

    function automatic logic [4:0] tb_index(input logic [1:0] s);
        case (s)
            2'h0: tb_index = `PCB_TB_BIT_47;
            2'h1: tb_index = `PCB_TB_BIT_51;
            2'h2: tb_index = `PCB_TB_BIT_55;
            default: tb_index = `PCB_TB_BIT_63;
        endcase
    endfunction

    function automatic logic is_ours(input logic [`PCB_SPR_W-1:0] n);
        is_ours = (n == `PCB_SPR_CTRL0) || (n == `PCB_SPR_CNT_B) ||
            (n == `PCB_SPR_INSTR_SMP) || (n == `PCB_SPR_OPND_SMP);
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tb_prev_q;
    logic tb_prev_d;
    pcb_int_state_t int_q;
    pcb_int_state_t int_d;
    logic take_q;
    logic take_d;
    pcb_rd_src_t rd_src_q;
    pcb_rd_src_t rd_src_d;
    logic [31:0] rd_hold_q;
    logic [31:0] rd_hold_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic fault_q;
    logic fault_d;

    logic access_ok;
    logic access_bad;
    logic wr_ok;
    logic rd_ok;
    logic [5:0] sel;
    logic tb_bit;
    logic tb_toggle;
    logic [2:0] incr;
    logic signal_int;
    logic cap_en;
    logic [31:0] cap_instr;
    logic [31:0] cap_opnd;
    logic store_wr;
    logic store_idx;
    logic [31:0] store_rdata;

    // ----------------------------------------
    // access decode
    // ----------------------------------------
    always_comb begin
        access_ok = is_ours(spr_req_in.num) && spr_req_in.supervisor;
        access_bad = is_ours(spr_req_in.num) && !spr_req_in.supervisor &&
            (spr_req_in.rd || spr_req_in.wr);
        wr_ok = access_ok && spr_req_in.wr;
        rd_ok = access_ok && spr_req_in.rd;
        store_wr = wr_ok && ((spr_req_in.num == `PCB_SPR_INSTR_SMP) ||
            (spr_req_in.num == `PCB_SPR_OPND_SMP));
        store_idx = (spr_req_in.num == `PCB_SPR_OPND_SMP) ? `PCB_IDX_OPND :
            `PCB_IDX_INSTR;
    end

    // ----------------------------------------
    // event selection
    // ----------------------------------------
    always_comb begin
        sel = ctrl_q[`PCB_SEL_MSB:`PCB_SEL_LSB];
        tb_bit = tb_lower_in[tb_index(timebase_bit_selector_in)];
        tb_toggle = tb_bit != tb_prev_q;
        tb_prev_d = tb_bit;
        case (sel)
            `PCB_SEL_HOLD: incr = 3'h0;
            `PCB_SEL_CYCLES: incr = 3'h1;
            `PCB_SEL_COMPL: incr = quad_count(events_in.instr_completed);
            `PCB_SEL_TBTRANS: incr = one(tb_toggle);
            `PCB_SEL_DISP: incr = quad_count(events_in.instr_dispatched);
            `PCB_SEL_LDMISS: incr = one(events_in.load_miss_busy);
            `PCB_SEL_DCFILL: incr = one(events_in.dcache_fill);
            `PCB_SEL_ITLB: incr = one(events_in.itlb_miss);
            `PCB_SEL_BRANCH: begin
                incr = branch_count(events_in.branches_completed);
            end
            `PCB_SEL_RESV: incr = one(events_in.reservation_ok);
            `PCB_SEL_MFSPR: incr = one(events_in.mfspr_dispatched);
            `PCB_SEL_ICBI: incr = one(events_in.icbi_seen);
            `PCB_SEL_FLUSH: incr = one(events_in.flush_op);
            `PCB_SEL_BRU_RES: incr = one(events_in.bru_result);
            `PCB_SEL_SIU_RES: incr = one(events_in.siu_result);
            `PCB_SEL_CIU_RES: incr = one(events_in.ciu_result);
            `PCB_SEL_BRU_DSP: incr = one(events_in.bru_dispatch);
            `PCB_SEL_SIU_DSP: incr = one(events_in.siu_dispatch);
            `PCB_SEL_LOADS: incr = quad_count(events_in.loads_completed);
            `PCB_SEL_CIU_DSP: incr = one(events_in.ciu_dispatch);
            `PCB_SEL_SNOOP: incr = one(events_in.snoop_hit);
            default: incr = 3'h0;
        endcase
    end

    // ----------------------------------------
    // counter and control
    // ----------------------------------------
    always_comb begin
        signal_int = mon_int_req_in && ctrl_q[`PCB_INT_EN_BIT];
        ctrl_d = ctrl_q;
        if (wr_ok && (spr_req_in.num == `PCB_SPR_CTRL0)) begin
            ctrl_d = spr_req_in.wdata;
        end
        if (signal_int) begin
            ctrl_d[`PCB_INT_EN_BIT] = 1'b0;
        end
        cnt_d = cnt_q;
        if (wr_ok && (spr_req_in.num == `PCB_SPR_CNT_B)) begin
            cnt_d = spr_req_in.wdata;
        end else if (!ctrl_q[`PCB_DIS_BIT]) begin
            cnt_d = cnt_q + {29'h0, incr};
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ctrl_q <= `PCB_CTRL_RESET;
            cnt_q <= `PCB_CNT_RESET;
            tb_prev_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cnt_q <= cnt_d;
            tb_prev_q <= tb_prev_d;
        end
    end

    // ----------------------------------------
    // address sampling
    // ----------------------------------------
    always_comb begin
        cap_en = signal_int;
        if (mon_int_threshold_in) begin
            cap_instr = sample_src_in.thresh_instr_ea;
            cap_opnd = sample_src_in.thresh_operand_ea;
        end else begin
            cap_instr = sample_src_in.last_completed_ea;
            cap_opnd = sample_src_in.recent_operand_ea;
        end
    end

    pcb_sample_store u_store (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .cap_en_in(cap_en),
        .cap_instr_in(cap_instr),
        .cap_opnd_in(cap_opnd),
        .wr_en_in(store_wr),
        .wr_idx_in(store_idx),
        .wr_data_in(spr_req_in.wdata),
        .rd_idx_in(store_idx),
        .rd_data_out(store_rdata)
    );

    // ----------------------------------------
    // pending interrupt
    // ----------------------------------------
    always_comb begin
        int_d = int_q;
        take_d = 1'b0;
        case (int_q)
            PCB_INT_IDLE: begin
                if (signal_int) begin
                    int_d = PCB_INT_PENDING;
                end
            end
            PCB_INT_PENDING: begin
                if (external_interrupt_enable_in) begin
                    take_d = 1'b1;
                    int_d = signal_int ? PCB_INT_PENDING : PCB_INT_IDLE;
                end
            end
            default: int_d = PCB_INT_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            int_q <= PCB_INT_IDLE;
            take_q <= 1'b0;
        end else begin
            int_q <= int_d;
            take_q <= take_d;
        end
    end

    // ----------------------------------------
    // read answer, two cycles
    // ----------------------------------------
    always_comb begin
        rd_src_d = PCB_RD_NONE;
        rd_hold_d = rd_hold_q;
        if (rd_ok) begin
            if (spr_req_in.num == `PCB_SPR_CTRL0) begin
                rd_src_d = PCB_RD_CTRL;
                rd_hold_d = ctrl_q;
            end else if (spr_req_in.num == `PCB_SPR_CNT_B) begin
                rd_src_d = PCB_RD_CNT;
                rd_hold_d = cnt_q;
            end else begin
                rd_src_d = PCB_RD_STORE;
            end
        end
        case (rd_src_q)
            PCB_RD_STORE: rdata_d = store_rdata;
            PCB_RD_CTRL: rdata_d = rd_hold_q;
            PCB_RD_CNT: rdata_d = rd_hold_q;
            default: rdata_d = spr_rdata_out;
        endcase
        rvalid_d = rd_src_q != PCB_RD_NONE;
        fault_d = access_bad;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            rd_src_q <= PCB_RD_NONE;
            rd_hold_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            rd_src_q <= rd_src_d;
            rd_hold_q <= rd_hold_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            fault_q <= fault_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_comb begin
        spr_rdata_out = rdata_q;
        spr_rd_valid_out = rvalid_q;
        spr_priv_fault_out = fault_q;
        monitor_interrupt_pending_out = int_q == PCB_INT_PENDING;
        monitor_interrupt_take_out = take_q;
        event_counter_b_out = cnt_q;
    end

endmodule

// >>> verilog/pcb_pkg.sv
`include "pcb_defines.svh"

package pcb_pkg;

    // ----------------------------------------
    // per-cycle event indications
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] instr_completed;
        logic [2:0] instr_dispatched;
        logic load_miss_busy;
        logic dcache_fill;
        logic itlb_miss;
        logic [1:0] branches_completed;
        logic reservation_ok;
        logic mfspr_dispatched;
        logic icbi_seen;
        logic flush_op;
        logic bru_result;
        logic siu_result;
        logic ciu_result;
        logic bru_dispatch;
        logic siu_dispatch;
        logic ciu_dispatch;
        logic [2:0] loads_completed;
        logic snoop_hit;
    } pcb_evt_t;

    // ----------------------------------------
    // addresses offered for sampling
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] thresh_instr_ea;
        logic [31:0] thresh_operand_ea;
        logic [31:0] last_completed_ea;
        logic [31:0] recent_operand_ea;
    } pcb_sample_src_t;

    // ----------------------------------------
    // special register move request
    // ----------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [`PCB_SPR_W-1:0] num;
        logic [31:0] wdata;
        logic supervisor;
    } pcb_spr_req_t;

    typedef enum logic [1:0] {
        PCB_RD_NONE = 2'h0,
        PCB_RD_CTRL = 2'h1,
        PCB_RD_CNT = 2'h2,
        PCB_RD_STORE = 2'h3
    } pcb_rd_src_t;

    typedef enum logic {
        PCB_INT_IDLE = 1'h0,
        PCB_INT_PENDING = 1'h1
    } pcb_int_state_t;

endpackage

// >>> verilog/pcb_sample_store.sv
`timescale 1ns/1ps

module pcb_sample_store
    import pcb_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic cap_en_in,
    input wire logic [31:0] cap_instr_in,
    input wire logic [31:0] cap_opnd_in,
    input wire logic wr_en_in,
    input wire logic wr_idx_in,
    input wire logic [31:0] wr_data_in,
    input wire logic rd_idx_in,
    output logic [31:0] rd_data_out
);

    logic [1:0][31:0] mem_q;
    logic [1:0][31:0] mem_d;
    logic [31:0] rd_data_d;

    // ----------------------------------------
    // capture beats a software write
    // ----------------------------------------
    always_comb begin
        mem_d = mem_q;
        if (cap_en_in) begin
            mem_d[`PCB_IDX_INSTR] = cap_instr_in;
            mem_d[`PCB_IDX_OPND] = cap_opnd_in;
        end else if (wr_en_in) begin
            mem_d[wr_idx_in] = wr_data_in;
        end
        rd_data_d = mem_q[rd_idx_in];
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            mem_q <= {2{`PCB_SAMPLE_RESET}};
            rd_data_out <= `PCB_SAMPLE_RESET;
        end else begin
            mem_q <= mem_d;
            rd_data_out <= rd_data_d;
        end
    end

endmodule
